/* File: core/lsfb_pkg.sv */
/*
 * Constants for the link status flag bank: register indices, bit positions,
 * field values, completion codes and timing.
 * Assumes a 10 MHz system clock and a word-addressed register bus.
 */
// Overview of operation
// [R1] Remote error sets summary, alarm flashes, program runs
// [R2] Only first remote record shown; check toggle steps
// [R3] Bit 03 marks remote unit error; 01-02 zero
// [R4] Bits 04-06 binary; bits 08-15 two hex digits
// [R5] Master/slave error: digit B, master, slave rack
// [R6] Optical error: unit number, bit 04 upper byte
// [R7] Step record on check bit falling edge
// [R8] Absent link bits act as plain work bits
// [R9] Host unit error sets flag; restart by toggle
// [R10] Rack level 1 host: error 06, restart 07
// [R11] Rack level 0 host: restart 25213, error 25311
// [R12] Processor host unit: error 08, restart 09
// [R13] Multilevel rack host: restart toggle does nothing
// [R14] Failed transfer sets that level's error flag
// [R15] Software enables level before transfers run
// [R16] Data link active flag follows level's link
// [R17] Loop status: level 0 low, level 1 high
// [R18] Each transfer writes 8-bit code per level
// [R19] Code word upper byte level 1, lower level 0
// [R20] Bus codes 00 to 04 as listed
// [R21] Bus codes 05 to 09 as listed
// [R22] Loop codes 00-02 shared; 03 busy, 04, 05
// [R23] Loop codes 06 no response, 07 bad format
package lsfb_pkg;
    localparam logic [7:0] IDX_LOOP = 8'hec;
    localparam logic [7:0] IDX_CODE = 8'hed;
    localparam logic [7:0] IDX_RIO = 8'hfb;
    localparam logic [7:0] IDX_LINK = 8'hfc;
    localparam logic [7:0] IDX_SYS = 8'hfd;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam int B_CHECK = 0;
    localparam int B_RIO_ERR = 3;
    localparam int B_ERR0 = 0;
    localparam int B_EN0 = 1;
    localparam int B_ACT0 = 2;
    localparam int B_ERR1 = 3;
    localparam int B_EN1 = 4;
    localparam int B_ACT1 = 5;
    localparam int B_HERR_R1 = 6;
    localparam int B_HRST_R1 = 7;
    localparam int B_HERR_CPU = 8;
    localparam int B_HRST_CPU = 9;
    localparam int B_HRST_R0 = 13;
    localparam int B_HERR_R0 = 11;
    localparam int B_RIO_SUM = 12;
    localparam logic [15:0] LINK_WR_MASK = 16'hbbff;
    localparam logic [3:0] MS_DIGIT = 4'hb;
    localparam logic [7:0] CODE_NORMAL = 8'h00;
    localparam logic [7:0] CODE_PARAM = 8'h01;
    localparam logic [7:0] CODE_NO_TX = 8'h02;
    localparam logic [7:0] BUS_NO_DEST = 8'h03;
    localparam logic [7:0] BUS_BUSY = 8'h04;
    localparam logic [7:0] BUS_TIMEOUT = 8'h05;
    localparam logic [7:0] BUS_RESP_ERR = 8'h06;
    localparam logic [7:0] BUS_CTRL_ERR = 8'h07;
    localparam logic [7:0] BUS_SET_ERR = 8'h08;
    localparam logic [7:0] BUS_CPU_ERR = 8'h09;
    localparam logic [7:0] LOOP_BUSY = 8'h03;
    localparam logic [7:0] LOOP_NO_TOKEN = 8'h04;
    localparam logic [7:0] LOOP_FAULT = 8'h05;
    localparam logic [7:0] LOOP_NO_RESP = 8'h06;
    localparam logic [7:0] LOOP_BAD_FMT = 8'h07;
    localparam int CLK_HZ = 10000000;
    localparam int BLINK_HALF_MS = 500;
    localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int RIO_DEPTH = 8;
endpackage

/* File: core/lsfb_bank.sv */
/*
 * Link status flag bank: remote I/O error queue, host unit flags and
 * restart pulses, network level flags, loop status and completion codes,
 * all behind an Avalon-MM slave with waitrequest.
 * Assumes all link-unit inputs are synchronous to i_mclk.
 */
`timescale 1ns/100ps
`default_nettype none
module lsfb_bank #(
    parameter int RIO_DEPTH = lsfb_pkg::RIO_DEPTH,
    parameter int BLINK_CYCLES = lsfb_pkg::BLINK_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_rio_err_valid,
    input wire logic i_rio_err_optical,
    input wire logic [4:0] i_rio_unit,
    input wire logic [2:0] i_rio_rack,
    input wire logic i_rio_upper,
    input wire logic [2:0] i_host_present,
    input wire logic i_host_multilevel,
    input wire logic [2:0] i_host_err,
    input wire logic [1:0] i_net_present,
    input wire logic [1:0] i_xfer_done,
    input wire logic [7:0] i_xfer_code0,
    input wire logic [7:0] i_xfer_code1,
    input wire logic [1:0] i_dlink_active,
    input wire logic [7:0] i_loop_status0,
    input wire logic [7:0] i_loop_status1,
    output logic [2:0] o_host_restart,
    output logic o_alarm_led
);
    localparam int AW = $clog2(RIO_DEPTH);
    localparam int BW = $clog2(BLINK_CYCLES);

    if (RIO_DEPTH < 2 || (RIO_DEPTH & (RIO_DEPTH - 1)) != 0)
    begin : g_chk_depth
        $error("RIO_DEPTH must be a power of two, at least 2");
    end
    if (BLINK_CYCLES < 2)
    begin : g_chk_blink
        $error("BLINK_CYCLES must be at least 2");
    end

    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [15:0] loop_reg, loop_next;
    logic [15:0] code_reg, code_next;
    logic [15:0] shown_reg, shown_next;
    logic [15:0] link_reg, link_next;
    logic herr0_reg, herr0_next;
    logic [2:0] rst_reg, rst_next;
    logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic [BW-1:0] blink_reg, blink_next;
    logic led_reg, led_next;
    logic [15:0] rio_mem [RIO_DEPTH];

    logic req, wr_en;
    logic [15:0] wmask, wmerge_link, rec_new, head;
    logic advance, load_direct, push, pop;
    logic [1:0] accept, fail;
    logic [2:0] rst_old, rst_new, rst_allow;

    assign head = rio_mem[rptr_reg];

    // Master/slave and optical records share bit 03 and the hex-digit field
    always_comb
    begin
        req = i_avs_read | i_avs_write;
        wr_en = i_avs_write & ~wait_reg;
        wmask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
        wmerge_link = (link_reg & ~wmask) | (i_avs_writedata[15:0] & wmask);
        if (i_rio_err_optical)
        begin
            rec_new = {3'h0, i_rio_unit, 3'h0, i_rio_upper, 4'h8}; // R6 R4 R3
        end
        else
        begin
            rec_new = {lsfb_pkg::MS_DIGIT, i_rio_unit[3:0], 1'b0, i_rio_rack,
                4'h8}; // R5 R4 R3
        end
    end

    // Bus slave: one wait cycle, then the answer; writes land on the
    // edge that the master sees waitrequest low
    always_comb
    begin
        wait_next = ~(req & wait_reg);
        rdata_next = rdata_reg;
        if (i_avs_read & wait_reg)
        begin
            case (i_avs_address)
                lsfb_pkg::IDX_LOOP: rdata_next = {16'h0000, loop_reg};
                lsfb_pkg::IDX_CODE: rdata_next = {16'h0000, code_reg};
                lsfb_pkg::IDX_RIO: rdata_next = {16'h0000, shown_reg};
                lsfb_pkg::IDX_LINK: rdata_next = {16'h0000, link_reg};
                lsfb_pkg::IDX_SYS:
                    rdata_next = {19'h00000, shown_reg[lsfb_pkg::B_RIO_ERR],
                        herr0_reg, 11'h000};
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    // Remote I/O queue: shown record plus pending ones behind it
    always_comb
    begin
        advance = wr_en && i_avs_address == lsfb_pkg::IDX_RIO &&
            i_avs_byteenable[0] && shown_reg[lsfb_pkg::B_CHECK] &&
            !i_avs_writedata[lsfb_pkg::B_CHECK]; // R7
        load_direct = i_rio_err_valid && (!shown_reg[lsfb_pkg::B_RIO_ERR] ||
            (advance && cnt_reg == '0)); // R2
        push = i_rio_err_valid && !load_direct &&
            cnt_reg != (AW+1)'(RIO_DEPTH);
        pop = advance && cnt_reg != '0;
        shown_next = shown_reg;
        if (wr_en && i_avs_address == lsfb_pkg::IDX_RIO && i_avs_byteenable[0])
        begin
            shown_next[lsfb_pkg::B_CHECK] = i_avs_writedata[lsfb_pkg::B_CHECK];
        end
        if (advance)
        begin
            shown_next = pop ? head : 16'h0000; // R2 R7
        end
        if (load_direct)
        begin
            shown_next = rec_new; // R1 R2
        end
        wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
        rptr_next = pop ? rptr_reg + 1'b1 : rptr_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Network levels: transfers count only on a present, enabled level
    always_comb
    begin
        accept[0] = i_xfer_done[0] & i_net_present[0] &
            link_reg[lsfb_pkg::B_EN0]; // R15
        accept[1] = i_xfer_done[1] & i_net_present[1] &
            link_reg[lsfb_pkg::B_EN1]; // R15
        fail[0] = accept[0] & (i_xfer_code0 != lsfb_pkg::CODE_NORMAL); // R14
        fail[1] = accept[1] & (i_xfer_code1 != lsfb_pkg::CODE_NORMAL); // R14
        code_next = code_reg;
        if (accept[0])
        begin
            code_next[7:0] = i_xfer_code0; // R18 R19 R20 R21
        end
        if (accept[1])
        begin
            code_next[15:8] = i_xfer_code1; // R18 R19 R22 R23
        end
        loop_next = {i_loop_status1, i_loop_status0}; // R17
    end

    // Link flags; software writes first, hardware sets win over clears
    always_comb
    begin
        link_next = link_reg;
        if (wr_en && i_avs_address == lsfb_pkg::IDX_LINK)
        begin
            link_next = wmerge_link & lsfb_pkg::LINK_WR_MASK; // R8
        end
        herr0_next = herr0_reg;
        if (wr_en && i_avs_address == lsfb_pkg::IDX_SYS &&
            i_avs_byteenable[1] && !i_host_present[0])
        begin
            herr0_next = i_avs_writedata[lsfb_pkg::B_HERR_R0]; // R8
        end
        rst_old = {link_reg[lsfb_pkg::B_HRST_CPU],
            link_reg[lsfb_pkg::B_HRST_R1], link_reg[lsfb_pkg::B_HRST_R0]};
        rst_new = {link_next[lsfb_pkg::B_HRST_CPU],
            link_next[lsfb_pkg::B_HRST_R1], link_next[lsfb_pkg::B_HRST_R0]};
        rst_allow = {1'b1, {2{~i_host_multilevel}}}; // R13
        rst_next = rst_old & ~rst_new & i_host_present & rst_allow; // R9
        if (rst_next[1])
        begin
            link_next[lsfb_pkg::B_HERR_R1] = 1'b0;
        end
        if (rst_next[2])
        begin
            link_next[lsfb_pkg::B_HERR_CPU] = 1'b0;
        end
        if (rst_next[0])
        begin
            herr0_next = 1'b0;
        end
        if (i_host_present[1] && i_host_err[1])
        begin
            link_next[lsfb_pkg::B_HERR_R1] = 1'b1; // R9 R10
        end
        if (i_host_present[2] && i_host_err[2])
        begin
            link_next[lsfb_pkg::B_HERR_CPU] = 1'b1; // R9 R12
        end
        if (i_host_present[0] && i_host_err[0])
        begin
            herr0_next = 1'b1; // R9 R11
        end
        if (fail[0])
        begin
            link_next[lsfb_pkg::B_ERR0] = 1'b1; // R14
        end
        if (fail[1])
        begin
            link_next[lsfb_pkg::B_ERR1] = 1'b1; // R14
        end
        if (i_net_present[0])
        begin
            link_next[lsfb_pkg::B_ACT0] = i_dlink_active[0]; // R16
        end
        if (i_net_present[1])
        begin
            link_next[lsfb_pkg::B_ACT1] = i_dlink_active[1]; // R16
        end
    end

    // Alarm flashes while an error record is shown; program is never halted
    always_comb
    begin
        blink_next = blink_reg + 1'b1;
        led_next = led_reg;
        if (blink_reg == BW'(BLINK_CYCLES - 1))
        begin
            blink_next = '0;
            led_next = ~led_reg;
        end
        if (!shown_reg[lsfb_pkg::B_RIO_ERR])
        begin
            blink_next = '0;
            led_next = 1'b0; // R1
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
            loop_reg <= lsfb_pkg::RESET_WORD;
            code_reg <= lsfb_pkg::RESET_WORD;
            shown_reg <= lsfb_pkg::RESET_WORD;
            link_reg <= lsfb_pkg::RESET_WORD;
            herr0_reg <= 1'b0;
            rst_reg <= 3'h0;
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
            blink_reg <= '0;
            led_reg <= 1'b0;
        end
        else
        begin
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            loop_reg <= loop_next;
            code_reg <= code_next;
            shown_reg <= shown_next;
            link_reg <= link_next;
            herr0_reg <= herr0_next;
            rst_reg <= rst_next;
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            cnt_reg <= cnt_next;
            blink_reg <= blink_next;
            led_reg <= led_next;
        end
    end

    // Queue storage needs no reset; count guards every read
    always_ff @(posedge i_mclk)
    begin
        if (push)
        begin
            rio_mem[wptr_reg] <= rec_new;
        end
    end

    assign o_avs_waitrequest = wait_reg;
    assign o_avs_readdata = rdata_reg;
    assign o_host_restart = rst_reg;
    assign o_alarm_led = led_reg;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);

    sequence s_first_err;
        i_rio_err_valid && !shown_reg[lsfb_pkg::B_RIO_ERR] && !advance;
    endsequence
    sequence s_step;
        advance && cnt_reg != '0 && !i_rio_err_valid;
    endsequence
    sequence s_cpu_restart;
        wr_en && i_avs_address == lsfb_pkg::IDX_LINK && i_host_present[2] &&
        link_reg[lsfb_pkg::B_HRST_CPU] && !wmerge_link[lsfb_pkg::B_HRST_CPU];
    endsequence

    AST_WAIT_ONE: assert property ( // bus slave wait cycle
        (req && wait_reg) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("waitrequest not low for exactly one cycle");
    AST_SUMMARY: assert property ( // R1
        s_first_err |=> shown_reg[lsfb_pkg::B_RIO_ERR] &&
        shown_reg[2:1] == 2'b00)
        else $error("remote error not reported");
    AST_MS_DIGIT: assert property ( // R5
        (s_first_err and !i_rio_err_optical) |=>
        shown_reg[15:12] == lsfb_pkg::MS_DIGIT &&
        shown_reg[6:4] == $past(i_rio_rack))
        else $error("master/slave record wrong");
    AST_OPTICAL: assert property ( // R6
        (s_first_err and i_rio_err_optical) |=>
        shown_reg[4] == $past(i_rio_upper) &&
        shown_reg[15:8] == {3'h0, $past(i_rio_unit)})
        else $error("optical record wrong");
    AST_ADVANCE: assert property ( // R7
        s_step |=> shown_reg == $past(head))
        else $error("queued record not stepped in");
    AST_XFER_ERR: assert property ( // R14
        fail[1] |=> link_reg[lsfb_pkg::B_ERR1] [*2])
        else $error("level 1 transfer error flag not set");
    AST_CODE_HI: assert property ( // R18
        accept[1] |=> code_reg[15:8] == $past(i_xfer_code1) &&
        (code_reg[7:0] == $past(code_reg[7:0], 1) || $past(accept[0])))
        else $error("level 1 completion code wrong");
    AST_NO_RESTART: assert property ( // R13
        i_host_multilevel |=> !o_host_restart[0] && !o_host_restart[1])
        else $error("multilevel rack unit restarted");
    AST_ACTIVE: assert property ( // R16
        i_net_present[0] |=> link_reg[lsfb_pkg::B_ACT0] ==
        $past(i_dlink_active[0]))
        else $error("level 0 link active flag wrong");
    AST_LOOP: assert property ( // R17
        ##1 loop_reg == {$past(i_loop_status1), $past(i_loop_status0)})
        else $error("loop status word wrong");
    AST_CPU_RESTART: assert property ( // R12
        s_cpu_restart |=> o_host_restart[2] ##1 !o_host_restart[2])
        else $error("processor host unit restart pulse wrong");
    AST_CODE_LO: assert property ( // R19
        accept[0] |=> code_reg[7:0] == $past(i_xfer_code0) &&
        (code_reg[15:8] == $past(code_reg[15:8], 1) || $past(accept[1])))
        else $error("level 0 completion code wrong");
    AST_XFER_ERR0: assert property ( // R14
        fail[0] |=> link_reg[lsfb_pkg::B_ERR0])
        else $error("level 0 transfer error flag not set");
    AST_NO_ENABLE: assert property ( // R15
        (i_xfer_done[1] && !link_reg[lsfb_pkg::B_EN1]) |=>
        code_reg[15:8] == $past(code_reg[15:8]))
        else $error("level 1 transfer taken while disabled");
    AST_HOST_ERR1: assert property ( // R10
        (i_host_present[1] && i_host_err[1]) |=>
        link_reg[lsfb_pkg::B_HERR_R1])
        else $error("rack level 1 host unit error flag not set");
    AST_HOST_ERR0: assert property ( // R11
        (i_host_present[0] && i_host_err[0]) |=> herr0_reg)
        else $error("rack level 0 host unit error flag not set");
    AST_ABSENT_HOST: assert property ( // R8
        !i_host_present[2] |=> !o_host_restart[2])
        else $error("restart pulse to an absent unit");
    AST_ALARM_OFF: assert property ( // R1
        !shown_reg[lsfb_pkg::B_RIO_ERR] |=> !o_alarm_led)
        else $error("alarm lit with no remote error shown");
    AST_BITS_UNUSED: assert property ( // R3
        shown_reg[2:1] == 2'b00 && shown_reg[7] == 1'b0)
        else $error("unused remote record bits set");
    AST_FIRST_KEPT: assert property ( // R2
        (shown_reg[lsfb_pkg::B_RIO_ERR] && !advance) |=>
        shown_reg[15:1] == $past(shown_reg[15:1]))
        else $error("shown remote record changed without a step");
endmodule
`default_nettype wire

/* File: test/lsfb_link_model.sv */
/*
 * Link-unit partner: remote I/O, host units and network levels.
 * Assumes tasks are entered just after a rising edge of i_mclk.
 */
`timescale 1ns/100ps
`default_nettype none
module lsfb_link_model (
    input wire logic i_mclk,
    output logic o_rio_err_valid,
    output logic o_rio_err_optical,
    output logic [4:0] o_rio_unit,
    output logic [2:0] o_rio_rack,
    output logic o_rio_upper,
    output logic [2:0] o_host_present,
    output logic o_host_multilevel,
    output logic [2:0] o_host_err,
    output logic [1:0] o_net_present,
    output logic [1:0] o_xfer_done,
    output logic [7:0] o_xfer_code0,
    output logic [7:0] o_xfer_code1,
    output logic [1:0] o_dlink_active,
    output logic [7:0] o_loop_status0,
    output logic [7:0] o_loop_status1
);
    initial
    begin
        {o_rio_err_valid, o_rio_err_optical, o_rio_unit, o_rio_rack} = '0;
        {o_rio_upper, o_host_present, o_host_multilevel, o_host_err} = '0;
        {o_net_present, o_xfer_done, o_xfer_code0, o_xfer_code1} = '0;
        {o_dlink_active, o_loop_status0, o_loop_status1} = '0;
    end
    task automatic set_cfg(input logic [2:0] hp, input logic ml,
        input logic [1:0] np, input logic [1:0] dl);
        @(posedge i_mclk);
        {o_host_present, o_host_multilevel} <= {hp, ml};
        {o_net_present, o_dlink_active} <= {np, dl};
        {o_loop_status0, o_loop_status1} <= {8'h5a, 8'ha5};
    endtask
    // Fields are inverted once the pulse ends, so no one may lean on them
    task automatic rio_error(input logic opt, input logic [4:0] u,
        input logic [2:0] rk, input logic up);
        @(posedge i_mclk);
        {o_rio_err_valid, o_rio_err_optical, o_rio_unit, o_rio_rack,
            o_rio_upper} <= {1'b1, opt, u, rk, up};
        @(posedge i_mclk);
        {o_rio_err_valid, o_rio_err_optical, o_rio_unit, o_rio_rack,
            o_rio_upper} <= {1'b0, ~opt, ~u, ~rk, ~up};
    endtask
    task automatic host_error(input logic [2:0] m);
        @(posedge i_mclk);
        o_host_err <= m;
        @(posedge i_mclk);
        o_host_err <= 3'b000;
    endtask
    task automatic xfer(input logic [1:0] d, input logic [7:0] c0,
        input logic [7:0] c1);
        @(posedge i_mclk);
        {o_xfer_done, o_xfer_code0, o_xfer_code1} <= {d, c0, c1};
        @(posedge i_mclk);
        {o_xfer_done, o_xfer_code0, o_xfer_code1} <= {2'b00, ~c0, ~c1};
    endtask
endmodule
`default_nettype wire

/* File: test/lsfb_bank_tb.sv */
/*
 * Self-checking bench for the link status flag bank over Avalon-MM.
 * Assumes the partner model drives every link-unit input.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
            n_errors++; \
        end \
    end
module lsfb_bank_tb;
    logic i_mclk = 1'b0;
    logic i_rstn, i_avs_read, i_avs_write, o_avs_waitrequest;
    logic [7:0] i_avs_address;
    logic [31:0] i_avs_writedata, o_avs_readdata, rdata;
    logic [3:0] i_avs_byteenable;
    logic i_rio_err_valid, i_rio_err_optical, i_rio_upper;
    logic [4:0] i_rio_unit;
    logic [2:0] i_rio_rack, i_host_present, i_host_err, o_host_restart;
    logic i_host_multilevel, o_alarm_led;
    logic [1:0] i_net_present, i_xfer_done, i_dlink_active;
    logic [7:0] i_xfer_code0, i_xfer_code1, i_loop_status0, i_loop_status1;
    logic [7:0] c;
    logic [15:0] rb [3] = '{16'h0080, 16'h0200, 16'h2000};
    logic [2:0] pm [3] = '{3'b010, 3'b100, 3'b001};
    logic [2:0] hp [3] = '{3'b111, 3'b111, 3'b000};
    logic ml [3] = '{1'b0, 1'b1, 1'b0};
    logic [2:0] e;
    logic [23:0] pulse_cnt = '0;
    logic [23:0] want = '0;
    int n_errors = 0;
    int check_count = 0;
    int n;
    always #50 i_mclk = ~i_mclk;
    always @(posedge i_mclk)
        pulse_cnt <= pulse_cnt + {7'h00, o_host_restart[2],
            7'h00, o_host_restart[1], 7'h00, o_host_restart[0]};
    lsfb_bank #(.BLINK_CYCLES(4)) uut (.i_mclk, .i_rstn, .i_avs_address,
        .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
        .o_avs_readdata, .o_avs_waitrequest, .i_rio_err_valid,
        .i_rio_err_optical, .i_rio_unit, .i_rio_rack, .i_rio_upper,
        .i_host_present, .i_host_multilevel, .i_host_err, .i_net_present,
        .i_xfer_done, .i_xfer_code0, .i_xfer_code1, .i_dlink_active,
        .i_loop_status0, .i_loop_status1, .o_host_restart, .o_alarm_led);
    lsfb_link_model partner (.i_mclk, .o_rio_err_valid(i_rio_err_valid),
        .o_rio_err_optical(i_rio_err_optical), .o_rio_unit(i_rio_unit),
        .o_rio_rack(i_rio_rack), .o_rio_upper(i_rio_upper),
        .o_host_present(i_host_present), .o_host_err(i_host_err),
        .o_host_multilevel(i_host_multilevel), .o_xfer_done(i_xfer_done),
        .o_net_present(i_net_present), .o_xfer_code0(i_xfer_code0),
        .o_xfer_code1(i_xfer_code1), .o_dlink_active(i_dlink_active),
        .o_loop_status0(i_loop_status0), .o_loop_status1(i_loop_status1));
    task automatic end_of_test();
        if (n_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [15:0] d);
        @(posedge i_mclk);
        {i_avs_address, i_avs_writedata} <= {a, 16'h0000, d};
        {i_avs_write, i_avs_read} <= {w, ~w};
        // Only the watchdog ends a wait that never sees the answer
        do
        begin
            @(posedge i_mclk);
        end
        while (o_avs_waitrequest !== 1'b0);
        rdata = o_avs_readdata;
        {i_avs_write, i_avs_read} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] x);
        bus(1'b0, a, 16'h0000);
        `CHK(rdata, {16'h0000, x})
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask
    initial
    begin
        repeat (20000) @(posedge i_mclk);
        n_errors++;
        end_of_test();
    end
    initial
    begin
        {i_rstn, i_avs_read, i_avs_write, i_avs_address} = '0;
        {i_avs_writedata, i_avs_byteenable} = {32'h0, 4'h3};
        repeat (12) @(posedge i_mclk);
        i_rstn <= 1'b1;
        for (n = 0; n < 5; n++)
            rd(8'hec + 8'(n), 16'h0000);
        rd(8'hfe, 16'h0000);
        rd(8'hfb, 16'h0000);
        rd(8'hfc, 16'h0000);
        rd(8'hfd, 16'h0000);
        wr(8'hec, 16'hffff);
        wr(8'hed, 16'hffff);
        rd(8'hec, 16'h0000);
        rd(8'hed, 16'h0000);
        partner.rio_error(1'b0, 5'h01, 3'h5, 1'b0);
        partner.rio_error(1'b1, 5'h11, 3'h0, 1'b1);
        rd(8'hfb, 16'hb158);
        rd(8'hfd, 16'h1000);
        for (n = 0; n < 20 && o_alarm_led !== 1'b1; n++)
            @(posedge i_mclk);
        `CHK(o_alarm_led, 1'b1)
        wr(8'hfb, 16'h0001);
        i_avs_byteenable <= 4'h2;
        wr(8'hfb, 16'h0000);
        i_avs_byteenable <= 4'h3;
        rd(8'hfb, 16'hb159);
        wr(8'hfb, 16'h0000);
        rd(8'hfb, 16'h1118);
        wr(8'hfb, 16'h0001);
        wr(8'hfb, 16'h0000);
        rd(8'hfb, 16'h0000);
        rd(8'hfd, 16'h0000);
        repeat (3) @(posedge i_mclk);
        `CHK(o_alarm_led, 1'b0)
        wr(8'hfc, 16'hffff);
        rd(8'hfc, 16'hbbff);
        wr(8'hfd, 16'hffff);
        rd(8'hfd, 16'h0800);
        wr(8'hfd, 16'h0000);
        wr(8'hfc, 16'h0000);
        `CHK(pulse_cnt, want)
        partner.set_cfg(3'b111, 1'b0, 2'b00, 2'b00);
        partner.host_error(3'b111);
        rd(8'hfc, 16'h0140);
        rd(8'hfd, 16'h0800);
        for (int g = 0; g < 3; g++)
        begin
            partner.set_cfg(hp[g], ml[g], 2'b00, 2'b00);
            for (int k = 0; k < 3; k++)
            begin
                wr(8'hfc, rb[k]);
                wr(8'hfc, 16'h0000);
                repeat (3) @(posedge i_mclk);
                e = pm[k] & hp[g] & (ml[g] ? 3'b100 : 3'b111);
                want = want + {7'h00, e[2], 7'h00, e[1], 7'h00, e[0]};
                `CHK(pulse_cnt, want)
            end
        end
        rd(8'hfd, 16'h0000);
        partner.set_cfg(3'b000, 1'b0, 2'b11, 2'b01);
        partner.xfer(2'b11, 8'h05, 8'h05);
        rd(8'hed, 16'h0000);
        rd(8'hfc, 16'h0004);
        wr(8'hfc, 16'h0012);
        for (int k = 0; k < 10; k++)
        begin
            c = 8'(k);
            partner.xfer(2'b11, c, 8'h09 - c);
            rd(8'hed, {8'h09 - c, c});
            rd(8'hfc, 16'h0016 | {15'h0, c != 8'h00}
                | {12'h000, c != 8'h09, 3'h0});
            wr(8'hfc, 16'h0012);
        end
        partner.xfer(2'b10, 8'h03, 8'h07);
        rd(8'hed, 16'h0709);
        rd(8'hfc, 16'h001e);
        wr(8'hfc, 16'h0012);
        rd(8'hec, 16'ha55a);
        partner.set_cfg(3'b000, 1'b0, 2'b11, 2'b00);
        rd(8'hfc, 16'h0012);
        end_of_test();
    end
endmodule
`default_nettype wire
